// ### hdl/tsi_pkg.sv
package tsi_pkg;

   localparam int CLK_HZ      = 100_000_000;
   localparam int CLK_PER_US  = CLK_HZ / 1_000_000;

   // Bus timeout: a line held low this long inside a frame drops the interface
   localparam int TIMEOUT_MS  = 28;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

   // Spike suppression on the sampled lines; a longest time, so it rounds down
   localparam int FILT_FM_NS  = 50;
   localparam int FILT_HS_NS  = 10;
   localparam int FILT_FM_RAW = (FILT_FM_NS * CLK_PER_US) / 1000;
   localparam int FILT_HS_RAW = (FILT_HS_NS * CLK_PER_US) / 1000;
   localparam int FILT_FM_CYC = (FILT_FM_RAW < 1) ? 1 : FILT_FM_RAW;
   localparam int FILT_HS_CYC = (FILT_HS_RAW < 1) ? 1 : FILT_HS_RAW;
   localparam int FILT_W      = 4;

   // Bus addresses and command bytes
   localparam logic [4:0] ADDR_FIXED   = 5'h12;
   localparam logic [6:0] GC_ADDR      = 7'h00;
   localparam logic [7:0] ARA_BYTE     = 8'h19;
   localparam logic [7:0] GC_LATCH     = 8'h04;
   localparam logic [7:0] GC_RESET     = 8'h06;
   localparam logic [4:0] HS_CODE_HI   = 5'h01;

   // Pointer after power-up, and the pointer value of the configuration register
   localparam logic [7:0] PTR_RST      = 8'h00;
   localparam logic [7:0] CFG_PTR_DFLT = 8'h01;
   localparam logic [1:0] ASEL_RST     = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX   = 3'b001,
      ST_RACK = 3'b011,
      ST_TX   = 3'b010,
      ST_MACK = 3'b110,
      ST_WAIT = 3'b100
   } tsi_state_t;

   // What the byte now on the bus means
   typedef enum logic [2:0] {
      K_ADDR = 3'h0,
      K_PTR  = 3'h1,
      K_MSB  = 3'h2,
      K_LSB  = 3'h3,
      K_GC   = 3'h4,
      K_RD   = 3'h5,
      K_ARA  = 3'h6
   } tsi_kind_t;

   typedef struct packed {
      logic       msb_stb;
      logic       lsb_stb;
      logic [7:0] data;
   } tsi_wr_t;

endpackage

// ### hdl/tsi_sync.sv
`timescale 1ns/1ps
module tsi_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_q;
         logic hold_q;
         // Idle bus lines are high, so both stages start high
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               meta_q <= 1'b1;
               hold_q <= 1'b1;
            end else begin
               meta_q <= d[gi];
               hold_q <= meta_q;
            end
         end
         assign q[gi] = hold_q;
      end
   endgenerate

endmodule // tsi_sync

// ### hdl/tsi_slave.sv
// How it works
// - First byte after our write address is stored as the pointer.
// - Reads return the pointed register; reads never change the pointer.
// - A write of address plus pointer only is accepted and acknowledged.
// - Two-byte values travel upper byte first, then lower byte.
// - Receiver acknowledges address, pointer and each data byte; data goes to register.
// - A write ending after the upper byte updates that upper byte alone.
// - On read address, send upper then lower byte, each with master ack slot.
// - Master not-acknowledge makes the device release SDA.
// - Alert response address with event line active: acknowledge, return address plus status.
// - Status bit is 1 for upper_limit event, 0 for lower_limit event.
// - Arbitrate while sending; in interrupt mode winner clears event line at completion, loser keeps it.
// - Acknowledge general-call address with write direction and act on next byte.
// - General-call 00000100 re-samples addr_select_pin without register reset.
// - General-call 00000110 returns all registers to power-up values.
// - General-call address-acquire command causes no address action.
// - High-speed master code is not acknowledged but selects high-speed filtering.
// - High-speed filtering stays through repeated starts, ends at stop.
// - SCL or SDA low 28 ms inside a frame resets the interface.
// - Receiver keeps acknowledging data bytes as long as they arrive.
// - Acknowledging side holds SDA low across the whole acknowledge clock pulse.
// - Address is 10010xx; low bits from pin tied to ground, supply, SDA or SCL.
// - Address pin level is sampled at the start of each communication.
// - In interrupt mode the event line clears by config read, alert response, reset.
// - Alert response clears only the line; config read clears flags and line.
`timescale 1ns/1ps
module tsi_slave
   import tsi_pkg::*;
#(
   parameter int         TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter logic [7:0] CFG_PTR        = CFG_PTR_DFLT
) (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       scl_pin,
   input  wire logic       sda_pin,
   input  wire logic       addr_select_pin,
   input  wire logic       limit_event_line,
   input  wire logic       event_over,
   input  wire logic       interrupt_mode_select,
   input  wire logic [7:0] rd_msb,
   input  wire logic [7:0] rd_lsb,
   output logic            sda_o_q,
   output logic            sda_oe_q,
   output logic [7:0]      ptr_q,
   output tsi_wr_t         wr_q,
   output logic            cfg_read_stb_q,
   output logic            alert_clr_stb_q,
   output logic            gc_reset_stb_q,
   output logic [6:0]      bus_addr_q,
   output logic            hs_mode_q,
   output logic            busy_q
);

   localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

   logic [2:0]        raw;
   logic [1:0]        filt;
   logic [FILT_W-1:0] flim;
   logic              scl_d_q;
   logic              sda_d_q;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_ev;
   logic              stop_ev;
   logic              timeout_ev;
   logic              decide_ev;
   logic [TO_W-1:0]   to_cnt_q;

   tsi_state_t        state_q;
   tsi_kind_t         kind_q;
   tsi_kind_t         nk_c;
   logic [2:0]        cnt_q;
   logic [7:0]        sh_q;
   logic              have_q;
   logic              first_q;
   logic              tx_lsb_q;
   logic              ack_c;
   logic              hs_c;
   logic [7:0]        rd_next;

   logic              pin_hi_q;
   logic              pin_lo_q;
   logic              pin_ne_sda_q;
   logic [1:0]        asel_q;
   logic [1:0]        cls_now;
   logic [6:0]        own_addr;

   // Lines and strap pass the two-flop synchroniser before anything looks at them
   tsi_sync #(.WIDTH(3)) u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .d        ({addr_select_pin, sda_pin, scl_pin}),
      .q        (raw)
   );

   assign flim = hs_mode_q ? FILT_W'(FILT_HS_CYC - 1) : FILT_W'(FILT_FM_CYC - 1);

   // Filter index 0 is SCL, 1 is SDA; a level must hold flim+1 cycles to pass
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         logic              f_q;
         logic [FILT_W-1:0] c_q;
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               f_q <= 1'b1;
               c_q <= '0;
            end else if (raw[gi] == f_q) begin
               c_q <= '0;
            end else if (c_q >= flim) begin
               f_q <= raw[gi];
               c_q <= '0;
            end else begin
               c_q <= c_q + 1'b1;
            end
         end
         assign filt[gi] = f_q;
      end
   endgenerate

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         scl_d_q <= filt[0];
         sda_d_q <= filt[1];
      end
   end

   assign scl_rise  = filt[0] & ~scl_d_q;
   assign scl_fall  = ~filt[0] & scl_d_q;
   assign start_ev  = filt[0] & scl_d_q & sda_d_q & ~filt[1];
   assign stop_ev   = filt[0] & scl_d_q & ~sda_d_q & filt[1];
   assign decide_ev = (state_q == ST_RX) && scl_fall && have_q;

   // Timeout counts any low line while a frame is open; idle needs both high anyway
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         to_cnt_q <= '0;
      end else if (state_q == ST_IDLE || (filt[0] && filt[1]) || timeout_ev) begin
         to_cnt_q <= '0;
      end else begin
         to_cnt_q <= to_cnt_q + 1'b1;
      end
   end
   assign timeout_ev = (to_cnt_q == TO_W'(TIMEOUT_CYCLES - 1));

   // Strap classification: tied to ground or supply never moves; tied to a line,
   // it follows that line through the byte just received
   function automatic logic [1:0] classify(input logic hi, input logic lo, input logic ne);
      logic [1:0] r;
      r = 2'b11;
      if (!hi) begin
         r = 2'b00;
      end else if (!lo) begin
         r = 2'b01;
      end else if (!ne) begin
         r = 2'b10;
      end
      return r;
   endfunction

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_hi_q     <= 1'b0;
         pin_lo_q     <= 1'b0;
         pin_ne_sda_q <= 1'b0;
      end else if (start_ev || state_q == ST_RACK) begin
         pin_hi_q     <= 1'b0;
         pin_lo_q     <= 1'b0;
         pin_ne_sda_q <= 1'b0;
      end else if (state_q == ST_RX) begin
         pin_hi_q     <= pin_hi_q | raw[2];
         pin_lo_q     <= pin_lo_q | ~raw[2];
         pin_ne_sda_q <= pin_ne_sda_q | (raw[2] ^ raw[1]);
      end
   end

   assign cls_now  = classify(pin_hi_q, pin_lo_q, pin_ne_sda_q);
   assign own_addr = {ADDR_FIXED, cls_now};

   // Latched strap: refreshed by each address byte and by the latch command
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         asel_q <= ASEL_RST;
      end else if (decide_ev && kind_q == K_ADDR) begin
         asel_q <= cls_now;
      end else if (decide_ev && kind_q == K_GC && sh_q == GC_LATCH) begin
         asel_q <= cls_now;
      end
   end

   // Meaning of a completed byte, resolved on the falling edge after bit 8
   always_comb begin
      ack_c = 1'b0;
      hs_c  = 1'b0;
      nk_c  = kind_q;
      case (kind_q)
         K_ADDR: begin
            if (sh_q[7:1] == own_addr) begin
               ack_c = 1'b1;
               nk_c  = sh_q[0] ? K_RD : K_PTR;
            end else if (sh_q == ARA_BYTE && limit_event_line) begin
               ack_c = 1'b1;
               nk_c  = K_ARA;
            end else if (sh_q[7:1] == GC_ADDR && !sh_q[0]) begin
               ack_c = 1'b1;
               nk_c  = K_GC;
            end else if (sh_q[7:3] == HS_CODE_HI && first_q) begin
               hs_c  = 1'b1;
            end
         end
         K_PTR: begin
            ack_c = 1'b1;
            nk_c  = K_MSB;
         end
         K_MSB: begin
            ack_c = 1'b1;
            nk_c  = K_LSB;
         end
         K_LSB: begin
            ack_c = 1'b1;
            nk_c  = K_MSB;
         end
         K_GC: begin
            // Every command byte is taken; only latch and reset act
            ack_c = 1'b1;
            nk_c  = K_GC;
         end
         default: begin
            ack_c = 1'b0;
         end
      endcase
   end

   assign rd_next = tx_lsb_q ? rd_lsb : rd_msb;

   // Bit and byte engine; SDA only changes just after SCL falls, so the
   // acknowledge and data bits are steady over the whole high phase
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q  <= ST_IDLE;
         kind_q   <= K_ADDR;
         cnt_q    <= 3'h0;
         sh_q     <= 8'h00;
         have_q   <= 1'b0;
         first_q  <= 1'b0;
         tx_lsb_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (timeout_ev) begin
         state_q  <= ST_IDLE;
         sda_oe_q <= 1'b0;
      end else if (start_ev) begin
         state_q  <= ST_RX;
         kind_q   <= K_ADDR;
         cnt_q    <= 3'h0;
         have_q   <= 1'b0;
         first_q  <= 1'b1;
         sda_oe_q <= 1'b0;
      end else if (stop_ev) begin
         state_q  <= ST_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (state_q)
            ST_RX: begin
               if (scl_rise && !have_q) begin
                  sh_q  <= {sh_q[6:0], filt[1]};
                  cnt_q <= cnt_q + 3'h1;
                  if (cnt_q == 3'h7) begin
                     have_q <= 1'b1;
                  end
               end else if (decide_ev) begin
                  first_q <= 1'b0;
                  if (ack_c) begin
                     state_q  <= ST_RACK;
                     kind_q   <= nk_c;
                     sda_oe_q <= 1'b1;
                  end else begin
                     state_q  <= ST_WAIT;
                  end
               end
            end
            ST_RACK: begin
               if (scl_fall) begin
                  cnt_q  <= 3'h0;
                  have_q <= 1'b0;
                  if (kind_q == K_RD) begin
                     state_q  <= ST_TX;
                     sh_q     <= rd_msb;
                     sda_oe_q <= ~rd_msb[7];
                     tx_lsb_q <= 1'b1;
                  end else if (kind_q == K_ARA) begin
                     state_q  <= ST_TX;
                     sh_q     <= {bus_addr_q, event_over};
                     sda_oe_q <= ~bus_addr_q[6];
                  end else begin
                     state_q  <= ST_RX;
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise && kind_q == K_ARA && sh_q[7] && !filt[1]) begin
                  state_q  <= ST_WAIT;
                  sda_oe_q <= 1'b0;
               end else if (scl_fall) begin
                  if (cnt_q == 3'h7) begin
                     state_q  <= ST_MACK;
                     sda_oe_q <= 1'b0;
                  end else begin
                     cnt_q    <= cnt_q + 3'h1;
                     sh_q     <= {sh_q[6:0], 1'b1};
                     sda_oe_q <= ~sh_q[6];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise && (filt[1] || kind_q == K_ARA)) begin
                  state_q <= ST_WAIT;
               end else if (scl_fall) begin
                  state_q  <= ST_TX;
                  cnt_q    <= 3'h0;
                  sh_q     <= rd_next;
                  sda_oe_q <= ~rd_next[7];
                  tx_lsb_q <= ~tx_lsb_q;
               end
            end
            ST_WAIT: begin
               sda_oe_q <= 1'b0;
            end
            default: begin
               state_q  <= ST_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // Pointer survives any number of reads; only a pointer byte or reset moves it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ptr_q <= PTR_RST;
      end else if (decide_ev && kind_q == K_GC && sh_q == GC_RESET) begin
         ptr_q <= PTR_RST;
      end else if (decide_ev && kind_q == K_PTR) begin
         ptr_q <= sh_q;
      end
   end

   // Each data byte is strobed when it completes, so a write cut short after
   // the upper byte leaves the lower byte untouched
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
      end else begin
         wr_q.msb_stb <= decide_ev && kind_q == K_MSB;
         wr_q.lsb_stb <= decide_ev && kind_q == K_LSB;
         if (decide_ev) begin
            wr_q.data <= sh_q;
         end
      end
   end

   // Event-line side effects for the comparator logic outside this block
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_read_stb_q  <= 1'b0;
         alert_clr_stb_q <= 1'b0;
         gc_reset_stb_q  <= 1'b0;
      end else begin
         cfg_read_stb_q  <= (state_q == ST_RACK) && scl_fall && !start_ev && !stop_ev &&
                            !timeout_ev && kind_q == K_RD && ptr_q == CFG_PTR;
         alert_clr_stb_q <= (state_q == ST_MACK) && scl_rise && kind_q == K_ARA &&
                            !start_ev && !stop_ev && !timeout_ev &&
                            interrupt_mode_select;
         gc_reset_stb_q  <= decide_ev && kind_q == K_GC && sh_q == GC_RESET;
      end
   end

   // Held across repeated starts; only a stop or a dropped frame ends it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hs_mode_q <= 1'b0;
      end else if (stop_ev || timeout_ev) begin
         hs_mode_q <= 1'b0;
      end else if (decide_ev && hs_c) begin
         hs_mode_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bus_addr_q <= {ADDR_FIXED, ASEL_RST};
         busy_q     <= 1'b0;
         sda_o_q    <= 1'b0;
      end else begin
         bus_addr_q <= {ADDR_FIXED, asel_q};
         busy_q     <= (state_q != ST_IDLE);
         sda_o_q    <= 1'b0;
      end
   end

endmodule // tsi_slave

// ### test/tsi_slave_sva.sv
`timescale 1ns/1ps
module tsi_slave_sva
   import tsi_pkg::*;
#(
   parameter int         TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter logic [7:0] CFG_PTR        = CFG_PTR_DFLT
) (
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire logic       scl_pin,
   input wire logic       limit_event_line,
   input wire logic       interrupt_mode_select,
   input wire logic       sda_o_q,
   input wire logic       sda_oe_q,
   input wire logic [7:0] ptr_q,
   input wire tsi_wr_t    wr_q,
   input wire logic       cfg_read_stb_q,
   input wire logic       alert_clr_stb_q,
   input wire logic       gc_reset_stb_q,
   input wire logic [6:0] bus_addr_q,
   input wire logic       hs_mode_q,
   input wire logic       busy_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic        msb_open_q;
   logic [31:0] low_cnt_q;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) msb_open_q <= 1'b0;
      else if (wr_q.msb_stb) msb_open_q <= 1'b1;
      else if (wr_q.lsb_stb || !busy_q) msb_open_q <= 1'b0;
   end
   // Saturates so a long idle low never wraps back into range
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) low_cnt_q <= '0;
      else if (scl_pin) low_cnt_q <= '0;
      else if (low_cnt_q < TIMEOUT_CYCLES + 200) low_cnt_q <= low_cnt_q + 1;
   end
   property p_open_drain;
      sda_o_q == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda level not low");
   property p_ptr_in_frame;
      !$stable(ptr_q) |-> $past(busy_q);
   endproperty
   a_ptr_in_frame: assert property (p_ptr_in_frame) else $error("pointer moved idle");
   property p_wr_strobe;
      wr_q.msb_stb || wr_q.lsb_stb |-> busy_q && !(wr_q.msb_stb && wr_q.lsb_stb);
   endproperty
   a_wr_strobe: assert property (p_wr_strobe) else $error("bad write strobe");
   property p_lsb_after_msb;
      wr_q.lsb_stb |-> msb_open_q;
   endproperty
   a_lsb_after_msb: assert property (p_lsb_after_msb) else $error("lower before upper");
   property p_hs_on;
      $rose(hs_mode_q) |-> busy_q;
   endproperty
   a_hs_on: assert property (p_hs_on) else $error("fast filter left outside frame");
   property p_hs_off;
      $fell(hs_mode_q) |-> ##[0:2] !busy_q;
   endproperty
   a_hs_off: assert property (p_hs_off) else $error("fast filter back inside frame");
   property p_alert_clr;
      alert_clr_stb_q |-> interrupt_mode_select && limit_event_line ##1 !alert_clr_stb_q;
   endproperty
   a_alert_clr: assert property (p_alert_clr) else $error("bad alert clear");
   property p_gc_reset;
      gc_reset_stb_q |-> ##[0:1] ptr_q == PTR_RST;
   endproperty
   a_gc_reset: assert property (p_gc_reset) else $error("pointer kept on reset");
   property p_cfg_read;
      cfg_read_stb_q |-> ptr_q == CFG_PTR && busy_q;
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("bad config read strobe");
   property p_addr_fixed;
      bus_addr_q[6:2] == ADDR_FIXED;
   endproperty
   a_addr_fixed: assert property (p_addr_fixed) else $error("address high bits wrong");
   property p_idle_release;
      !busy_q [*2] |-> !sda_oe_q;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("sda held idle");
   property p_timeout;
      low_cnt_q == TIMEOUT_CYCLES + 100 |-> !busy_q;
   endproperty
   a_timeout: assert property (p_timeout) else $error("no bus timeout");
endmodule // tsi_slave_sva

bind tsi_slave tsi_slave_sva #(
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
   .CFG_PTR       (CFG_PTR)
) u_sva (
   .core_clk(core_clk), .resetn(resetn), .scl_pin(scl_pin),
   .limit_event_line(limit_event_line), .interrupt_mode_select(interrupt_mode_select),
   .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q), .ptr_q(ptr_q), .wr_q(wr_q),
   .cfg_read_stb_q(cfg_read_stb_q), .alert_clr_stb_q(alert_clr_stb_q),
   .gc_reset_stb_q(gc_reset_stb_q), .bus_addr_q(bus_addr_q), .hs_mode_q(hs_mode_q),
   .busy_q(busy_q)
);

// ### test/tsi_bus_master.sv
`timescale 1ns/1ps
module tsi_bus_master (
   output logic      scl_pin,
   output logic      sda_low,
   input  wire logic sda_pin
);
   // Not a multiple of the core period, so bus edges wander against it
   localparam int STEP = 41;
   initial {scl_pin, sda_low} = 2'b10;
   // Data moves a third into the low phase; released data floats high on the pull-up
   task automatic put_bit(input logic b, output logic r);
      #(STEP) sda_low = !b;
      #(2*STEP) scl_pin = 1'b1;
      #(STEP) r = sda_pin;
      #(STEP) scl_pin = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(v[i], r);
      put_bit(1'b1, r);
      ack = !r;
   endtask
   // Bits set in pull are driven low by us, to beat the slave in arbitration
   task automatic recv_byte(input logic [7:0] pull, input logic nack, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(!pull[i], r);
         v[i] = r;
      end
      put_bit(nack, r);
   endtask
   // Waits out the slave's release after the previous fall before SCL goes high
   task automatic start();
      #(2*STEP) sda_low = 1'b0;
      #(STEP) scl_pin = 1'b1;
      #(2*STEP) sda_low = 1'b1;
      #(2*STEP) scl_pin = 1'b0;
   endtask
   task automatic stop();
      #(STEP) sda_low = 1'b1;
      #(STEP) scl_pin = 1'b1;
      #(2*STEP) sda_low = 1'b0;
      #(4*STEP);
   endtask
endmodule // tsi_bus_master

// ### test/test_temp_sensor_i2c_slave.sv
`timescale 1ns/1ps
module test_temp_sensor_i2c_slave;
   import tsi_pkg::*;
   localparam int TO_CYC = 2000;
   logic       core_clk = 1'b0;
   logic       resetn = 1'b0;
   logic       addr_select_pin = 1'b0;
   logic       strap_sda = 1'b0;
   logic       limit_event_line = 1'b0;
   logic       event_over = 1'b0;
   logic       interrupt_mode_select = 1'b1;
   logic       scl_pin, sda_low, sda_wire, sda_o_q, sda_oe_q;
   logic       cfg_read_stb_q, alert_clr_stb_q, gc_reset_stb_q, hs_mode_q, busy_q;
   logic [7:0] rd_msb, rd_lsb, ptr_q, rx, msb_val, lsb_val;
   logic [6:0] bus_addr_q;
   tsi_wr_t    wr_q;
   int         num_errors = 0;
   int         check_count = 0;
   int         msb_cnt, lsb_cnt, cfg_cnt, clr_cnt, gc_cnt;

   always #5 core_clk = !core_clk;
   assign sda_wire = !(sda_low || sda_oe_q);
   // Register bank stand-in: bytes that follow from the pointer
   assign rd_msb = {ptr_q[3:0], 4'h9};
   assign rd_lsb = ~ptr_q;

   tsi_slave #(.TIMEOUT_CYCLES(TO_CYC)) dut (
      .core_clk(core_clk), .resetn(resetn), .scl_pin(scl_pin), .sda_pin(sda_wire),
      .addr_select_pin(strap_sda ? sda_wire : addr_select_pin), .limit_event_line(limit_event_line),
      .event_over(event_over), .interrupt_mode_select(interrupt_mode_select),
      .rd_msb(rd_msb), .rd_lsb(rd_lsb), .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q),
      .ptr_q(ptr_q), .wr_q(wr_q), .cfg_read_stb_q(cfg_read_stb_q),
      .alert_clr_stb_q(alert_clr_stb_q), .gc_reset_stb_q(gc_reset_stb_q),
      .bus_addr_q(bus_addr_q), .hs_mode_q(hs_mode_q), .busy_q(busy_q));
   tsi_bus_master master (.scl_pin(scl_pin), .sda_low(sda_low), .sda_pin(sda_wire));

   always @(posedge core_clk) begin
      if (wr_q.msb_stb === 1'b1) begin
         msb_cnt++;
         msb_val = wr_q.data;
      end
      if (wr_q.lsb_stb === 1'b1) begin
         lsb_cnt++;
         lsb_val = wr_q.data;
      end
      if (cfg_read_stb_q === 1'b1) cfg_cnt++;
      if (alert_clr_stb_q === 1'b1) clr_cnt++;
      if (gc_reset_stb_q === 1'b1) gc_cnt++;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic clr(input string name);
      $display("test %s", name);
      msb_cnt = 0;
      lsb_cnt = 0;
      cfg_cnt = 0;
      gc_cnt = 0;
   endtask
   task automatic xfer(input logic [7:0] b[$], input logic exp_ack);
      logic a;
      master.start();
      foreach (b[i]) begin
         master.send_byte(b[i], a);
         chk("ack", {7'h00, exp_ack}, {7'h00, a});
      end
   endtask
   task automatic alert(input logic over, input logic mode, input logic [7:0] pull,
                        input logic [7:0] exp, input int exp_clr);
      tick();
      event_over = over;
      interrupt_mode_select = mode;
      xfer('{ARA_BYTE}, 1'b1);
      master.recv_byte(pull, 1'b1, rx);
      master.stop();
      chk("alert reply", exp, rx);
      chk("alert clears", exp_clr[7:0], clr_cnt[7:0]);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #800_000;
      num_errors++;
      $display("mismatch watchdog expected end seen hang");
      conclude();
   end

   initial begin
      clr_cnt = 0;
      repeat (4) @(posedge core_clk);
      #1 resetn = 1'b1;
      repeat (10) tick();
      clr("write");
      xfer('{8'h90, 8'h03, 8'ha5, 8'h3c, 8'h5e}, 1'b1);
      master.stop();
      chk("pointer", 8'h03, ptr_q);
      chk("upper count", 8'd2, msb_cnt[7:0]);
      chk("lower count", 8'd1, lsb_cnt[7:0]);
      chk("upper data", 8'h5e, msb_val);
      chk("lower data", 8'h3c, lsb_val);
      clr("upper only");
      xfer('{8'h90, 8'h02, 8'h77}, 1'b1);
      master.start();
      master.stop();
      chk("upper count", 8'd1, msb_cnt[7:0]);
      chk("lower count", 8'd0, lsb_cnt[7:0]);
      chk("upper data", 8'h77, msb_val);
      clr("pointer then read");
      xfer('{8'h90, CFG_PTR_DFLT}, 1'b1);
      xfer('{8'h91}, 1'b1);
      master.recv_byte(8'h00, 1'b0, rx);
      chk("read upper", 8'h19, rx);
      master.recv_byte(8'h00, 1'b1, rx);
      chk("read lower", 8'hfe, rx);
      repeat (20) tick();
      chk("released", 8'h00, {7'h00, sda_oe_q});
      master.stop();
      chk("config reads", 8'd1, cfg_cnt[7:0]);
      xfer('{8'h91}, 1'b1);
      master.recv_byte(8'h00, 1'b1, rx);
      master.stop();
      chk("reread upper", 8'h19, rx);
      chk("pointer kept", CFG_PTR_DFLT, ptr_q);
      clr("address strap");
      for (int p = 0; p < 2; p++) begin
         tick();
         addr_select_pin = p[0];
         xfer('{8'h90}, !p[0]);
         master.stop();
         xfer('{8'h92}, p[0]);
         master.stop();
         chk("address", {1'b0, ADDR_FIXED, 1'b0, p[0]}, {1'b0, bus_addr_q});
      end
      clr("general call");
      tick();
      strap_sda = 1'b1;
      xfer('{8'h00, GC_LATCH}, 1'b1);
      master.stop();
      chk("relatched", 8'h4a, {1'b0, bus_addr_q});
      chk("no reset", CFG_PTR_DFLT, ptr_q);
      tick();
      {strap_sda, addr_select_pin} = 2'b00;
      xfer('{8'h00, GC_RESET, 8'h07}, 1'b1);
      master.stop();
      chk("resets", 8'd1, gc_cnt[7:0]);
      chk("pointer reset", PTR_RST, ptr_q);
      clr("alert response");
      xfer('{ARA_BYTE}, 1'b0);
      master.stop();
      tick();
      limit_event_line = 1'b1;
      alert(1'b1, 1'b1, 8'h00, 8'h91, 1);
      alert(1'b0, 1'b0, 8'h00, 8'h90, 1);
      alert(1'b1, 1'b1, 8'h80, 8'h7f, 1);
      tick();
      limit_event_line = 1'b0;
      clr("high speed");
      xfer('{8'h0b}, 1'b0);
      chk("hs on", 8'h01, {7'h00, hs_mode_q});
      xfer('{8'h90, 8'h05}, 1'b1);
      chk("hs kept", 8'h01, {7'h00, hs_mode_q});
      master.stop();
      chk("hs off", 8'h00, {7'h00, hs_mode_q});
      clr("timeout");
      xfer('{8'h90}, 1'b1);
      repeat (TO_CYC + 200) tick();
      chk("frame dropped", 8'h00, {7'h00, busy_q});
      master.stop();
      xfer('{8'h90, 8'h07}, 1'b1);
      master.stop();
      chk("pointer after", 8'h07, ptr_q);
      conclude();
   end
endmodule // test_temp_sensor_i2c_slave
